// File: pkg/mrd_defs.svh
// constants for the memory read ecc datapath
// assumes one memory cycle clock; included by package and modules
`ifndef MRD_DEFS_SVH
`define MRD_DEFS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define MRD_DATA_W   16
`define MRD_CHK_W    6
`define MRD_WORD_W   22
`define MRD_ACC_W    24
`define MRD_ROT_W    5
`define MRD_STACKS   3

// ----------------------------------------
// field positions
// ----------------------------------------
`define MRD_PAR_BIT  16
`define MRD_CHK_LSB  17
`define MRD_AWD_CHK  18

// ----------------------------------------
// syndrome code
// ----------------------------------------
`define MRD_DATA_WT  3
`define MRD_CHK_WT   1

`endif

// File: pkg/mrd_pkg.sv
// types and code helpers for the memory read ecc datapath
// assumes mrd_defs.svh is on the include path
`include "mrd_defs.svh"

package mrd_pkg;

  typedef logic [`MRD_DATA_W-1:0] mrd_data_t;
  typedef logic [`MRD_CHK_W-1:0]  mrd_chk_t;
  typedef logic [`MRD_WORD_W-1:0] mrd_word_t;
  typedef logic [`MRD_ACC_W-1:0]  mrd_acc_t;
  typedef logic [`MRD_ROT_W-1:0]  mrd_rot_t;

  typedef enum logic [1:0] {MRD_ERR_NONE, MRD_ERR_CHECK, MRD_ERR_DATA, MRD_ERR_MULTI} mrd_err_t;

  typedef enum logic [2:0] {MRD_PH_IDLE, MRD_PH_T0, MRD_PH_T1, MRD_PH_T2, MRD_PH_DATA} mrd_phase_t;

  // column of data bit i: the i-th weight-three code in ascending order
  function automatic mrd_chk_t mrd_hcol(input int i);
    int n;
    mrd_chk_t c;
    n = 0;
    c = '0;
    for (int v = 0; v < (1 << `MRD_CHK_W); v++) begin
      if ($countones(v[`MRD_CHK_W-1:0]) == `MRD_DATA_WT) begin
        if (n == i) c = v[`MRD_CHK_W-1:0];
        n++;
      end
    end
    return c;
  endfunction : mrd_hcol

  function automatic mrd_chk_t mrd_ecc(input mrd_data_t d);
    mrd_chk_t c;
    c = '0;
    for (int i = 0; i < `MRD_DATA_W; i++) begin
      if (d[i]) c = c ^ mrd_hcol(i);
    end
    return c;
  endfunction : mrd_ecc

endpackage : mrd_pkg

// File: verilog/mrd_rotator.sv
// 16-bit right rotator built as two levels of 4-way shifting
// assumes amount is steady within the cycle; purely combinational
`timescale 1ns/1ps
`include "mrd_defs.svh"

module mrd_rotator
  import mrd_pkg::*;
(
  // data
  input  wire logic [`MRD_DATA_W-1:0] i_data,
  input  wire logic [3:0]             i_amt,
  output logic      [`MRD_DATA_W-1:0] o_data
);
  import mrd_pkg::*;

  logic [2*`MRD_DATA_W-1:0] dbl1;
  logic [2*`MRD_DATA_W-1:0] dbl2;
  logic [`MRD_DATA_W-1:0]   lvl1;

  // first level: 0..3, second level: 0,4,8,12
  assign dbl1   = {i_data, i_data} >> i_amt[1:0];
  assign lvl1   = dbl1[`MRD_DATA_W-1:0];
  assign dbl2   = {lvl1, lvl1} >> {i_amt[3:2], 2'h0};
  assign o_data = dbl2[`MRD_DATA_W-1:0];

endmodule : mrd_rotator

// File: verilog/mrd_syndrome.sv
// syndrome generation, fast correction decode, full classification
// assumes storage bits arrive inverted; purely combinational
`timescale 1ns/1ps
`include "mrd_defs.svh"

module mrd_syndrome
  import mrd_pkg::*;
(
  // storage word, inverted
  input  wire logic [`MRD_WORD_W-1:0] i_raw_inverted_read_bit,
  input  wire logic                   i_corr_en,
  // results
  output logic      [`MRD_DATA_W-1:0] o_corrected_read_bit,
  output logic      [`MRD_CHK_W-1:0]  o_syndrome,
  output mrd_pkg::mrd_err_t           o_err_class
);
  import mrd_pkg::*;

  mrd_word_t true_word;
  mrd_data_t bit_correct_n;
  mrd_data_t col_hit;
  mrd_chk_t  data_par;
  logic      is_check;
  logic      is_data;

  assign true_word = ~i_raw_inverted_read_bit;
  assign data_par  = mrd_ecc(true_word[`MRD_DATA_W-1:0]);
  assign o_syndrome = data_par ^ true_word[`MRD_WORD_W-1:`MRD_DATA_W];

  // ----------------------------------------
  // fast decode and per-bit correction
  // ----------------------------------------
  // one compare per bit keeps it shallow; a multi-bit syndrome may hit one
  genvar gi;
  generate
    for (gi = 0; gi < `MRD_DATA_W; gi++) begin : g_bit
      assign col_hit[gi] = (o_syndrome == mrd_hcol(gi));
      assign bit_correct_n[gi] = ~(col_hit[gi] & i_corr_en);
      assign o_corrected_read_bit[gi] =
        i_raw_inverted_read_bit[gi] ^ bit_correct_n[gi];
    end
  endgenerate

  // ----------------------------------------
  // full decode
  // ----------------------------------------
  assign is_check = ($countones(o_syndrome) == `MRD_CHK_WT);
  assign is_data  = |col_hit;
  assign o_err_class = (o_syndrome == '0) ? MRD_ERR_NONE :
                       is_check ? MRD_ERR_CHECK :
                       is_data  ? MRD_ERR_DATA : MRD_ERR_MULTI;

endmodule : mrd_syndrome

// File: verilog/mrd_read_datapath.sv
// read-side data path of the memory base unit: correct, rotate, mask,
// accumulate, append parity; write data capture and merge
// assumes all inputs are produced on i_clk by the cycle control logic
`timescale 1ns/1ps
`include "mrd_defs.svh"

// Summary of operation
// - take 22-bit word, 16 data 6 check
// - read to accumulator, write to merge
// - stack data accepted from T3 onward
// - zero syndrome means no error
// - one-hot syndrome is check-bit error
// - 16 of the 20 weight-three syndromes name one data bit
// - any other syndrome is multi-bit error
// - fast decode may flip on multi-bit
// - full decode logs, inverts check on write
// - correction disable keeps detection alive
// - check-bit errors are never corrected
// - one xor per bit restores polarity
// - short fields right-justified, upper bits zero
// - right rotate 0..15 in two levels
// - mask high loads data, low holds
// - top byte check plus parity when asked
// - clear accumulator in T1 of every read cycle
// - unmasked upper bits stay zero
// - odd parity over data as bit 16
// - write data captured in T2
// - rotate, merge, generate check, load word
// - rotation amount is five bits
module mrd_read_datapath
  import mrd_pkg::*;
#(
  parameter int STACKS_MAX = `MRD_STACKS
) (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_sys_rst,
  // cycle control
  input  wire logic                   i_cycle_start,
  input  wire logic                   i_op_read,
  input  wire logic                   i_op_write,
  input  wire logic                   i_op_fetch4,
  input  wire logic                   i_diag_read_write_op,
  input  wire logic                   i_corr_disable,
  // storage side
  input  wire logic                   i_stack_read_select,
  input  wire logic [`MRD_WORD_W-1:0] i_raw_inverted_read_bit,
  // field control
  input  wire logic [`MRD_ACC_W-1:0]  i_field_mask_lines,
  input  wire logic [`MRD_ROT_W-1:0]  i_rotate_amount,
  input  wire logic [`MRD_ACC_W-1:0]  i_write_data,
  // return side
  output logic      [`MRD_ACC_W-1:0]  o_read_accumulator,
  // write side
  output logic      [`MRD_ACC_W-1:0]  o_addr_writedata_reg,
  output logic      [`MRD_WORD_W-1:0] o_write_word_reg,
  output logic                        o_write_word_valid,
  output logic                        o_check_invert,
  // error log
  output logic      [7:0]             o_error_log_register,
  output logic                        o_error_log_update
);
  import mrd_pkg::*;

  generate
    if (STACKS_MAX < 1 || STACKS_MAX > `MRD_STACKS) begin : g_chk
      $error("STACKS_MAX must be 1 to 3");
    end
  endgenerate

  // ----------------------------------------
  // registers
  // ----------------------------------------
  mrd_phase_t phase_ff;
  mrd_phase_t nxt_phase;
  logic       op_rd_ff;
  logic       op_wr_ff;
  logic       op_f4_ff;
  logic       op_dg_ff;
  logic [1:0] stacks_ff;
  logic [1:0] nxt_stacks;
  mrd_acc_t   acc_ff;
  mrd_acc_t   nxt_acc;
  mrd_acc_t   addr_writedata_reg_ff;
  mrd_acc_t   nxt_addr_writedata_reg;
  mrd_word_t  wwr_ff;
  mrd_word_t  nxt_wwr;
  logic       wwr_vld_ff;
  logic       inv_ff;
  logic [7:0] error_log_register_ff;
  logic [7:0] nxt_error_log_register;
  logic       error_log_register_upd_ff;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic      accept;
  logic      acc_load;
  logic      wr_load;
  logic      clear_acc;
  logic      corr_en;
  logic      hi_chk;
  logic      parity;
  logic      multi;
  logic      err_seen;
  logic      cap_wd;
  logic [3:0] wr_amt;
  mrd_data_t corrected;
  mrd_data_t rot_rd;
  mrd_data_t rot_wd;
  mrd_data_t merged;
  mrd_chk_t  syndrome;
  mrd_chk_t  gen_chk;
  mrd_chk_t  wr_chk;
  mrd_chk_t  chk_true;
  mrd_err_t  err_class;
  logic [7:0] hi_byte;

  // storage data only counts once the cycle reaches T3
  assign accept    = i_stack_read_select && (phase_ff == MRD_PH_DATA) &&
                     (op_rd_ff || op_wr_ff) &&
                     (32'(stacks_ff) < STACKS_MAX);
  assign acc_load  = accept && op_rd_ff;
  assign wr_load   = accept && op_wr_ff;
  assign clear_acc = (phase_ff == MRD_PH_T1) && op_rd_ff;
  assign cap_wd    = (phase_ff == MRD_PH_T2) && op_wr_ff;
  assign corr_en   = ~(i_corr_disable | op_dg_ff);
  assign hi_chk    = op_f4_ff | op_dg_ff;
  assign chk_true  = ~i_raw_inverted_read_bit[`MRD_WORD_W-1:`MRD_DATA_W];
  assign parity    = ~(^corrected);
  assign hi_byte   = {1'b0, chk_true, parity};
  assign multi     = (err_class == MRD_ERR_MULTI);
  assign err_seen  = accept && (err_class != MRD_ERR_NONE);
  assign wr_amt    = 4'(-i_rotate_amount[3:0]);

  // ----------------------------------------
  // correction and rotation
  // ----------------------------------------
  mrd_syndrome u_syn (
    .i_raw_inverted_read_bit (i_raw_inverted_read_bit),
    .i_corr_en               (corr_en),
    .o_corrected_read_bit    (corrected),
    .o_syndrome              (syndrome),
    .o_err_class             (err_class)
  );

  mrd_rotator u_rot_rd (
    .i_data (corrected),
    .i_amt  (i_rotate_amount[3:0]),
    .o_data (rot_rd)
  );

  // left rotate expressed as right rotate by the complement amount
  mrd_rotator u_rot_wd (
    .i_data (addr_writedata_reg_ff[`MRD_DATA_W-1:0]),
    .i_amt  (wr_amt),
    .o_data (rot_wd)
  );

  assign merged  = (i_field_mask_lines[`MRD_DATA_W-1:0] & rot_wd) |
                   (~i_field_mask_lines[`MRD_DATA_W-1:0] & corrected);
  assign gen_chk = mrd_ecc(merged) ^ {`MRD_CHK_W{multi}};
  assign wr_chk  = op_dg_ff ? addr_writedata_reg_ff[`MRD_ACC_W-1:`MRD_AWD_CHK] : gen_chk;
  assign nxt_wwr = wr_load ? {wr_chk, merged} : wwr_ff;

  // ----------------------------------------
  // masker, one mux per accumulator bit
  // ----------------------------------------
  genvar gk;
  generate
    for (gk = 0; gk < `MRD_ACC_W; gk++) begin : g_acc
      if (gk >= `MRD_PAR_BIT) begin : g_hi
        assign nxt_acc[gk] = clear_acc ? 1'b0 :
          (acc_load && hi_chk) ? hi_byte[gk-`MRD_PAR_BIT] :
          (acc_load && i_field_mask_lines[gk]) ? rot_rd[gk-`MRD_PAR_BIT] :
          acc_ff[gk];
      end else begin : g_lo
        assign nxt_acc[gk] = clear_acc ? 1'b0 :
          (acc_load && i_field_mask_lines[gk]) ? rot_rd[gk] :
          acc_ff[gk];
      end
    end
  endgenerate

  // ----------------------------------------
  // cycle phase
  // ----------------------------------------
  always_comb begin
    nxt_phase = phase_ff;
    // the start cycle itself is T0, so the register shows T1 next
    if (i_cycle_start) begin
      nxt_phase = MRD_PH_T1;
    end else begin
      unique case (phase_ff)
        MRD_PH_IDLE: nxt_phase = MRD_PH_IDLE;
        MRD_PH_T0:   nxt_phase = MRD_PH_T1;
        MRD_PH_T1:   nxt_phase = MRD_PH_T2;
        MRD_PH_T2:   nxt_phase = MRD_PH_DATA;
        MRD_PH_DATA: nxt_phase = MRD_PH_DATA;
      endcase
    end
  end

  assign nxt_stacks = i_cycle_start ? 2'h0 : (accept ? stacks_ff + 2'h1 : stacks_ff);
  assign nxt_addr_writedata_reg   = cap_wd ? i_write_data : addr_writedata_reg_ff;
  assign nxt_error_log_register   = err_seen ? {err_class, syndrome} : error_log_register_ff;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      phase_ff  <= MRD_PH_IDLE;
      stacks_ff <= 2'h0;
    end else begin
      phase_ff  <= nxt_phase;
      stacks_ff <= nxt_stacks;
    end
  end

  // ops latched at T0 so they hold for the whole cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      op_rd_ff <= 1'b0;
      op_wr_ff <= 1'b0;
      op_f4_ff <= 1'b0;
      op_dg_ff <= 1'b0;
    end else if (i_cycle_start) begin
      op_rd_ff <= i_op_read;
      op_wr_ff <= i_op_write;
      op_f4_ff <= i_op_fetch4;
      op_dg_ff <= i_diag_read_write_op;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      acc_ff      <= '0;
      addr_writedata_reg_ff     <= '0;
      wwr_ff      <= '0;
      wwr_vld_ff  <= 1'b0;
      inv_ff      <= 1'b0;
      error_log_register_ff     <= 8'h00;
      error_log_register_upd_ff <= 1'b0;
    end else begin
      acc_ff      <= nxt_acc;
      addr_writedata_reg_ff     <= nxt_addr_writedata_reg;
      wwr_ff      <= nxt_wwr;
      wwr_vld_ff  <= wr_load;
      inv_ff      <= wr_load ? multi : inv_ff;
      error_log_register_ff     <= nxt_error_log_register;
      error_log_register_upd_ff <= err_seen;
    end
  end

  assign o_read_accumulator   = acc_ff;
  assign o_addr_writedata_reg = addr_writedata_reg_ff;
  assign o_write_word_reg     = wwr_ff;
  assign o_write_word_valid   = wwr_vld_ff;
  assign o_check_invert       = inv_ff;
  assign o_error_log_register = error_log_register_ff;
  assign o_error_log_update   = error_log_register_upd_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  property p_data_phase;
    i_cycle_start |=> !accept [*2];
  endproperty
  a_data_phase: assert property (p_data_phase) else $error("data taken before T3");

  property p_zero_syn;
    (syndrome == '0) |-> (err_class == MRD_ERR_NONE) && (corrected == ~i_raw_inverted_read_bit[15:0]);
  endproperty
  a_zero_syn: assert property (p_zero_syn) else $error("clean word altered");

  property p_chk_err;
    (err_class == MRD_ERR_CHECK) |-> (corrected == ~i_raw_inverted_read_bit[15:0]);
  endproperty
  a_chk_err: assert property (p_chk_err) else $error("check error corrected data");

  property p_detect_only;
    !corr_en |-> (corrected == ~i_raw_inverted_read_bit[15:0]);
  endproperty
  a_detect_only: assert property (p_detect_only) else $error("correction while disabled");

  property p_clear;
    clear_acc |=> (o_read_accumulator == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("accumulator not cleared");

  property p_hold;
    !clear_acc && !acc_load |=> $stable(o_read_accumulator);
  endproperty
  a_hold: assert property (p_hold) else $error("accumulator changed while idle");

  property p_parity;
    acc_load && hi_chk |=> (o_read_accumulator[16] == ~(^$past(corrected)));
  endproperty
  a_parity: assert property (p_parity) else $error("parity bit wrong");

  property p_mask_lo;
    acc_load && !hi_chk |=> (o_read_accumulator[15:0] ==
      (($past(i_field_mask_lines[15:0]) & $past(rot_rd)) |
       (~$past(i_field_mask_lines[15:0]) & $past(acc_ff[15:0]))));
  endproperty
  a_mask_lo: assert property (p_mask_lo) else $error("masked load wrong");

  property p_wd_cap;
    cap_wd |=> (o_addr_writedata_reg == $past(i_write_data)) ##1 $stable(o_addr_writedata_reg);
  endproperty
  a_wd_cap: assert property (p_wd_cap) else $error("write data not held");

  property p_inv;
    wr_load && multi |=> o_write_word_valid && o_check_invert;
  endproperty
  a_inv: assert property (p_inv) else $error("check not inverted");

  property p_route;
    acc_load |=> !o_write_word_valid;
  endproperty
  a_route: assert property (p_route) else $error("read went to write path");

  c_read3: cover property (acc_load ##1 acc_load ##1 acc_load);
  c_multi_wr: cover property (wr_load && multi);
  c_diag: cover property (acc_load && op_dg_ff && (err_class != MRD_ERR_NONE));
  c_fix: cover property (acc_load && (err_class == MRD_ERR_DATA));

endmodule : mrd_read_datapath

// File: tb/mrd_host_model.sv
// requester and storage board model for the read ecc datapath
// assumes the bench owns reset; every drive changes just after a rising edge
`timescale 1ns/1ps
`include "mrd_defs.svh"

module mrd_host_model (
  // clock and pulses watched
  input  wire logic        i_clk,
  input  wire logic        i_write_word_valid,
  input  wire logic        i_error_log_update,
  // cycle control
  output logic             o_cycle_start,
  output logic             o_op_read,
  output logic             o_op_write,
  output logic             o_op_fetch4,
  output logic             o_diag,
  output logic             o_corr_disable,
  // storage and field control
  output logic             o_sel,
  output logic [21:0]      o_raw,
  output logic [23:0]      o_mask,
  output logic [4:0]       o_rot,
  output logic [23:0]      o_wdata
);
  // ----------------------------------------
  // code columns, weight-three ascending
  // ----------------------------------------
  logic [5:0] cols [16] = '{6'h07, 6'h0B, 6'h0D, 6'h0E, 6'h13, 6'h15, 6'h16, 6'h19,
                            6'h1A, 6'h1C, 6'h23, 6'h25, 6'h26, 6'h29, 6'h2A, 6'h2C};
  logic       seen_wv;
  logic       seen_lu;

  initial begin
    {o_cycle_start, o_op_read, o_op_write, o_op_fetch4, o_diag, o_corr_disable} = '0;
    o_sel   = 1'b0;
    o_raw   = 22'h3FFFFF;
    o_mask  = 24'h000000;
    o_rot   = 5'h00;
    o_wdata = 24'h000000;
  end

  function automatic logic [5:0] vecc(input logic [15:0] d);
    logic [5:0] c;
    c = '0;
    for (int i = 0; i < 16; i++) begin
      if (d[i]) c = c ^ cols[i];
    end
    return c;
  endfunction : vecc

  // ----------------------------------------
  // one memory cycle; op is {read, write, fetch4, diag}
  // ----------------------------------------
  // stack s carries d+s and the mask rotated left by 8*(s mod 3)
  task automatic run(input logic [3:0] op, input logic [15:0] d, input logic [21:0] flip,
                     input logic [23:0] msk, input logic [4:0] rot, input int nstk,
                     input logic [23:0] wd);
    logic [15:0] ds;
    logic [47:0] tmp;
    @(posedge i_clk);
    {o_op_read, o_op_write, o_op_fetch4, o_diag} <= op;
    o_corr_disable <= op[0];
    o_cycle_start  <= 1'b1;
    o_rot          <= rot;
    @(posedge i_clk);
    o_cycle_start  <= 1'b0;
    @(posedge i_clk);
    o_wdata        <= wd;
    for (int s = 0; s < nstk; s++) begin
      @(posedge i_clk);
      ds = d + 16'(s);
      tmp = {msk, msk} >> (24 - 8 * (s % 3));
      o_sel  <= 1'b1;
      o_raw  <= ~{vecc(ds), ds} ^ flip;
      o_mask <= tmp[23:0];
    end
    @(posedge i_clk);
    // released lines show the inverse, never the last value
    o_sel   <= 1'b0;
    o_raw   <= ~o_raw;
    o_wdata <= ~wd;
    #1;
    seen_wv = i_write_word_valid;
    seen_lu = i_error_log_update;
    @(posedge i_clk);
    #1;
  endtask : run

endmodule : mrd_host_model

// File: tb/memory_read_ecc_datapath_bench.sv
// self-checking bench for the read ecc datapath
// assumes the host model drives all cycle, storage and field inputs
`timescale 1ns/1ps
`include "mrd_defs.svh"

module memory_read_ecc_datapath_bench;
  import mrd_pkg::*;
  logic        i_clk;
  logic        i_sys_rst;
  logic        cyc, rd, wr, f4, dg, cdis, sel;
  logic [21:0] raw;
  logic [23:0] msk, wdat, acc, addr_writedata_reg;
  logic [4:0]  rot;
  logic [21:0] wword;
  logic        wvalid, cinv, lupd;
  logic [7:0]  error_log_register;
  int          num_errors;
  int          n_tests;

  mrd_read_datapath #(.STACKS_MAX(3)) mrd_read_datapath_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cycle_start(cyc), .i_op_read(rd),
    .i_op_write(wr), .i_op_fetch4(f4), .i_diag_read_write_op(dg), .i_corr_disable(cdis),
    .i_stack_read_select(sel), .i_raw_inverted_read_bit(raw), .i_field_mask_lines(msk),
    .i_rotate_amount(rot), .i_write_data(wdat), .o_read_accumulator(acc),
    .o_addr_writedata_reg(addr_writedata_reg), .o_write_word_reg(wword), .o_write_word_valid(wvalid),
    .o_check_invert(cinv), .o_error_log_register(error_log_register), .o_error_log_update(lupd)
  );

  mrd_host_model mrd_host_model_inst (
    .i_clk(i_clk), .i_write_word_valid(wvalid), .i_error_log_update(lupd),
    .o_cycle_start(cyc), .o_op_read(rd), .o_op_write(wr), .o_op_fetch4(f4), .o_diag(dg),
    .o_corr_disable(cdis), .o_sel(sel), .o_raw(raw), .o_mask(msk), .o_rot(rot),
    .o_wdata(wdat)
  );

  // ----------------------------------------
  // compare and closing
  // ----------------------------------------
  task automatic chk(input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_clean();
    mrd_host_model_inst.run(4'b1000, 16'hA5C3, 22'h0, 24'h00FFFF, 5'h00, 1, 24'h0);
    chk(24'h00A5C3, acc);
    chk(24'h0, 24'(mrd_host_model_inst.seen_lu));
    $display("test clean read done");
  endtask : t_clean

  task automatic t_single();
    // bit 5 bad; top rotate bit set but read uses only the low four
    mrd_host_model_inst.run(4'b1000, 16'h00F0, 22'h000020, 24'h00FFFF, 5'h14, 1, 24'h0);
    chk(24'h00000F, acc);
    chk(24'({2'b10, mrd_host_model_inst.cols[5]}), 24'(error_log_register));
    chk(24'h1, 24'(mrd_host_model_inst.seen_lu));
    $display("test single data error done");
  endtask : t_single

  task automatic t_check();
    logic [5:0] c;
    c = mrd_host_model_inst.vecc(16'h1234) ^ 6'h04;
    mrd_host_model_inst.run(4'b1010, 16'h1234, 22'h040000, 24'h00FFFF, 5'h00, 1, 24'h0);
    chk({1'b0, c, ~^16'h1234, 16'h1234}, acc);
    chk(24'({2'b01, 6'h04}), 24'(error_log_register));
    $display("test check bit error done");
  endtask : t_check

  task automatic t_narrow();
    // upper byte was cleared in T1, so no check bits remain from the previous fetch
    mrd_host_model_inst.run(4'b1000, 16'h0008, 22'h0, 24'h000001, 5'h03, 1, 24'h0);
    chk(24'h000001, acc);
    $display("test single bit read done");
  endtask : t_narrow

  task automatic t_accum();
    // fourth select comes back onto byte 0 and must be ignored
    mrd_host_model_inst.run(4'b1000, 16'h8421, 22'h0, 24'h0000FF, 5'h00, 4, 24'h0);
    chk(24'h238421, acc);
    $display("test three stack accumulate done");
  endtask : t_accum

  task automatic t_write();
    logic [15:0] m;
    m = 16'hBEEA;
    mrd_host_model_inst.run(4'b0100, 16'hBEE0, 22'h000003, 24'h00000F, 5'h00, 1, 24'hC0FFEA);
    chk(24'hC0FFEA, addr_writedata_reg);
    chk(24'({~mrd_host_model_inst.vecc(m), m}), 24'(wword));
    chk(24'h3, 24'({cinv, mrd_host_model_inst.seen_wv}));
    chk(24'({2'b11, 6'h0C}), 24'(error_log_register));
    chk(24'h238421, acc);
    $display("test write with multi error done");
  endtask : t_write

  task automatic t_diag();
    mrd_host_model_inst.run(4'b1001, 16'h0F0F, 22'h000001, 24'h00FFFF, 5'h00, 1, 24'h0);
    chk({1'b0, mrd_host_model_inst.vecc(16'h0F0F), ~^16'h0F0E, 16'h0F0E}, acc);
    chk(24'({2'b10, 6'h07}), 24'(error_log_register));
    $display("test detect only diagnostic done");
  endtask : t_diag

  task automatic t_diag_wr();
    // clean diagnostic write: check bits come from write data, left rotate by 4
    mrd_host_model_inst.run(4'b0101, 16'h1234, 22'h0, 24'h0000FF, 5'h04, 1, 24'hA8005A);
    chk(24'h2A12A0, 24'(wword));
    chk(24'h1, 24'({cinv, mrd_host_model_inst.seen_wv}));
    chk(24'h0, 24'(mrd_host_model_inst.seen_lu));
    $display("test diagnostic write done");
  endtask : t_diag_wr

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial begin
    num_errors = 0;
    n_tests    = 0;
    i_sys_rst  = 1'b1;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    chk(24'h0, acc);
    t_clean();
    t_single();
    t_check();
    t_narrow();
    t_accum();
    t_write();
    t_diag();
    t_diag_wr();
    wrap_up();
  end

  // whole run is a few dozen cycles
  initial begin
    #100us;
    num_errors++;
    wrap_up();
  end

endmodule : memory_read_ecc_datapath_bench
